//--- core/duo_pkg.sv
// How it works
// - panel path bit picks panel controller
// - crt path bit picks crt controller
// - only controller 1 offers vga, expansion, centering
// - overlay shows only where controller 1 drives
// - clock select low/high nibbles per controller
// - two color tables, both enabled after reset, writes mirrored
// - path bit 7 picks cursor owner
// - path bit 6 picks icon owner
// - one cursor, one icon, controller 1 after reset
// - bank bit 3 low enables controller 1 writes
// - bank bit 2 high enables controller 2 writes
// - one write updates every enabled copy
// - bank bits 1-0 choose copy read back
// - paired registers: two copies, one address
// - shared registers: one copy feeds both
// - panel set 60-6F feeds panel controller
package duo_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;

  // register indices on the software port
  localparam logic [7:0] BANK_ACCESS_ADDR   = 8'h26;
  localparam logic [7:0] CLOCK_SELECT_ADDR  = 8'h28;
  localparam logic [7:0] PATH_ASSIGN_ADDR   = 8'h31;
  localparam logic [7:0] PANEL_FIRST_ADDR   = 8'h60;
  localparam logic [7:0] PANEL_RESERVED     = 8'h67;
  localparam logic [8:0] PANEL_COUNT        = 9'h010;
  localparam logic [7:0] PAIRED_BASE        = 8'h80;
  localparam logic [7:0] SHARED_BASE        = 8'hA0;
  localparam logic [7:0] TABLE_CONTROL_ADDR = 8'hC0;
  localparam logic [7:0] TABLE_INDEX_ADDR   = 8'hC1;
  localparam logic [7:0] TABLE_DATA_ADDR    = 8'hC2;

  // field positions
  localparam int BANK_WR1_BIT    = 3;
  localparam int BANK_WR2_BIT    = 2;
  localparam int BANK_RD_LSB     = 0;
  localparam int BANK_RD_MSB     = 1;
  localparam int CLK1_LSB        = 0;
  localparam int CLK1_MSB        = 3;
  localparam int CLK2_LSB        = 4;
  localparam int CLK2_MSB        = 7;
  localparam int PATH_PANEL_BIT  = 1;
  localparam int PATH_CRT_BIT    = 2;
  localparam int PATH_ICON_BIT   = 6;
  localparam int PATH_CURSOR_BIT = 7;

  // reset values
  localparam logic [7:0] BANK_ACCESS_RESET   = 8'h00;
  localparam logic [7:0] CLOCK_SELECT_RESET  = 8'h00;
  localparam logic [7:0] PATH_ASSIGN_RESET   = 8'h00;
  localparam logic [7:0] TABLE_CONTROL_RESET = 8'h03;
  localparam logic [7:0] ZERO_BYTE           = 8'h00;

  // which controller a path or resource follows
  typedef enum logic {
    CTRL1 = 1'b0,
    CTRL2 = 1'b1
  } ctrl_t;

  // read-back choice for paired registers
  typedef enum logic [1:0] {
    READ_CTRL1   = 2'b00,
    READ_CTRL2   = 2'b01,
    READ_CTRL1_B = 2'b10,
    READ_CTRL1_C = 2'b11
  } read_sel_t;

  // address falls inside [base, base+count)
  function automatic logic in_window(input logic [7:0] a,
                                     input logic [7:0] base,
                                     input logic [8:0] count);
    logic [8:0] ext;
    ext = {1'b0, a} - {1'b0, base};
    return ({1'b0, a} >= {1'b0, base}) && (ext < count);
  endfunction

endpackage

//--- core/paired_register_bank.sv
`timescale 1ns/1ps
module paired_register_bank #(
  parameter int COUNT = 8,
  parameter int AW    = $clog2(COUNT)
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    write,
  input  wire logic [AW-1:0]           index,
  input  wire logic [7:0]              wdata,
  input  wire logic                    write_first,
  input  wire logic                    write_second,
  input  wire logic                    read_second,
  output logic      [7:0]              rdata,
  output logic      [COUNT-1:0][7:0]   first_copy,
  output logic      [COUNT-1:0][7:0]   second_copy
);
  import duo_pkg::*;

  typedef struct packed {
    logic [COUNT-1:0][7:0] first;
    logic [COUNT-1:0][7:0] second;
  } bank_t;

  bank_t s;
  bank_t next_s;

  // each copy has its own gate, so one write may land in both
  always_comb begin
    next_s = s;
    if (write && write_first) begin
      next_s.first[index] = wdata;
    end
    if (write && write_second) begin
      next_s.second[index] = wdata;
    end
    if (rst) begin
      next_s = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end

  assign rdata       = read_second ? s.second[index] : s.first[index];
  assign first_copy  = s.first;
  assign second_copy = s.second;

endmodule // paired_register_bank

//--- core/color_table.sv
`timescale 1ns/1ps
module color_table #(
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic          ref_clk,
  input  wire logic          rst,
  input  wire logic          write,
  input  wire logic [AW-1:0] wr_index,
  input  wire logic [7:0]    wdata,
  input  wire logic [AW-1:0] rd_index,
  output logic      [7:0]    rd_data
);
  import duo_pkg::*;

  typedef struct packed {
    logic [DEPTH-1:0][7:0] entry;
    logic [7:0]            color;
  } table_t;

  table_t s;
  table_t next_s;

  // pixel lookup is registered, one cycle behind the index
  always_comb begin
    next_s = s;
    next_s.color = s.entry[rd_index];
    if (write) begin
      next_s.entry[wr_index] = wdata;
    end
    if (rst) begin
      next_s = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end

  assign rd_data = s.color;

endmodule // color_table

//--- core/dual_display_routing.sv
`timescale 1ns/1ps
module dual_display_routing #(
  parameter int PAIRED_COUNT = 8,
  parameter int SHARED_COUNT = 8,
  parameter int TABLE_DEPTH  = 16,
  parameter int PAIRED_AW    = $clog2(PAIRED_COUNT),
  parameter int SHARED_AW    = $clog2(SHARED_COUNT),
  parameter int TABLE_AW     = $clog2(TABLE_DEPTH)
) (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic [duo_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [duo_pkg::DATA_W-1:0]   reg_wdata,
  input  wire logic                         reg_write,
  input  wire logic                         reg_read,
  output logic      [duo_pkg::DATA_W-1:0]   reg_rdata,
  input  wire logic [TABLE_AW-1:0]          ctrl1_pixel_index,
  input  wire logic [TABLE_AW-1:0]          ctrl2_pixel_index,
  output logic      [7:0]                   ctrl1_color,
  output logic      [7:0]                   ctrl2_color,
  output logic                              panel_source,
  output logic                              crt_source,
  output logic                              cursor_owner,
  output logic                              icon_owner,
  output logic                              cursor_on_panel,
  output logic                              cursor_on_crt,
  output logic                              icon_on_panel,
  output logic                              icon_on_crt,
  output logic                              overlay_on_panel,
  output logic                              overlay_on_crt,
  output logic                              panel_expand_allowed,
  output logic                              panel_vga_capable,
  output logic                              crt_vga_capable,
  output logic      [3:0]                   ctrl1_clock_rate,
  output logic      [3:0]                   ctrl2_clock_rate,
  output logic      [PAIRED_COUNT*8-1:0]    ctrl1_timing,
  output logic      [PAIRED_COUNT*8-1:0]    ctrl2_timing,
  output logic      [SHARED_COUNT*8-1:0]    shared_timing,
  output logic      [16*8-1:0]              ctrl1_panel_timing,
  output logic      [16*8-1:0]              ctrl2_panel_timing
);
  import duo_pkg::*;

  // index step for the palette auto-increment; wraps at the table depth
  localparam logic [TABLE_AW-1:0] TABLE_STEP = TABLE_AW'(1);
  localparam int                  PANEL_N    = 16;

  // decodes that several outputs share live in functions, so the panel
  // and crt versions of one rule cannot drift apart

  // a path fed by controller 1 keeps vga, expansion and the overlay
  function automatic logic fed_by_ctrl1(input logic source);
    return (source == CTRL1);
  endfunction

  // the single cursor or icon shows wherever its owner is routed
  function automatic logic shown_on(input logic owner,
                                    input logic source);
    return (owner == source);
  endfunction

  // one strobe aimed at one fixed index
  function automatic logic strobe_at(input logic              strobe,
                                     input logic [ADDR_W-1:0] a,
                                     input logic [ADDR_W-1:0] target);
    return strobe && (a == target);
  endfunction

  typedef struct packed {
    logic [7:0]                     bank_access;
    logic [7:0]                     clock_select;
    logic [7:0]                     path_assign;
    logic [7:0]                     table_control;
    logic [TABLE_AW-1:0]            table_index;
    logic [SHARED_COUNT-1:0][7:0]   shared;
    logic [PANEL_N-1:0][7:0]        panel;
    logic [7:0]                     rdata;
  } state_t;

  state_t                        s;
  state_t                        next_s;

  logic                          paired_hit;
  logic                          shared_hit;
  logic                          panel_hit;
  logic                          paired_write;
  logic [7:0]                    paired_off;
  logic [7:0]                    shared_off;
  logic [7:0]                    panel_off;
  logic [PAIRED_AW-1:0]          paired_idx;
  logic [SHARED_AW-1:0]          shared_idx;
  logic [3:0]                    panel_idx;
  logic [7:0]                    paired_rdata;
  logic                          wr_gate1;
  logic                          wr_gate2;
  logic                          rd_second;
  read_sel_t                     rd_sel;
  logic [PAIRED_COUNT-1:0][7:0]  first_copy;
  logic [PAIRED_COUNT-1:0][7:0]  second_copy;
  logic [1:0]                    table_write;
  logic [1:0][TABLE_AW-1:0]      pixel_index;
  logic [1:0][7:0]               pixel_color;

  // address decode, shared by the write and the read paths;
  // the reserved panel slot decodes as unmapped so it never stores
  assign paired_hit = in_window(reg_addr, PAIRED_BASE, 9'(PAIRED_COUNT));
  assign shared_hit = in_window(reg_addr, SHARED_BASE, 9'(SHARED_COUNT));
  assign panel_hit  = in_window(reg_addr, PANEL_FIRST_ADDR, PANEL_COUNT)
                      && (reg_addr != PANEL_RESERVED);
  assign paired_off = reg_addr - PAIRED_BASE;
  assign shared_off = reg_addr - SHARED_BASE;
  assign panel_off  = reg_addr - PANEL_FIRST_ADDR;
  assign paired_idx = paired_off[PAIRED_AW-1:0];
  assign shared_idx = shared_off[SHARED_AW-1:0];
  assign panel_idx  = panel_off[3:0];

  // one strobe reaches the bank; the gates below pick which copies take it
  assign paired_write = reg_write && paired_hit;

  // write gates: controller 1 active low, controller 2 active high;
  // both open at once is how one write programs both timing sets
  assign wr_gate1 = ~s.bank_access[BANK_WR1_BIT];
  assign wr_gate2 = s.bank_access[BANK_WR2_BIT];

  // read-back select; only the one code picks the second copy, so the
  // two spare codes behave like the default and drivers that set them
  // still read controller 1
  assign rd_sel    = read_sel_t'(s.bank_access[BANK_RD_MSB:BANK_RD_LSB]);
  assign rd_second = (rd_sel == READ_CTRL2);

  // two physical copies behind every paired address
  // the bank reads combinationally; the flop on reg_rdata adds the cycle
  paired_register_bank #(
    .COUNT        (PAIRED_COUNT),
    .AW           (PAIRED_AW)
  ) u_paired (
    .ref_clk      (ref_clk),
    .rst          (rst),
    .write        (paired_write),
    .index        (paired_idx),
    .wdata        (reg_wdata),
    .write_first  (wr_gate1),
    .write_second (wr_gate2),
    .read_second  (rd_second),
    .rdata        (paired_rdata),
    .first_copy   (first_copy),
    .second_copy  (second_copy)
  );

  // register file; read data is zero except the cycle after a read
  always_comb begin
    next_s = s;
    next_s.rdata = ZERO_BYTE;
    if (reg_write) begin
      case (reg_addr)
        BANK_ACCESS_ADDR: begin
          next_s.bank_access = reg_wdata;
        end
        CLOCK_SELECT_ADDR: begin
          next_s.clock_select = reg_wdata;
        end
        PATH_ASSIGN_ADDR: begin
          next_s.path_assign = reg_wdata;
        end
        TABLE_CONTROL_ADDR: begin
          next_s.table_control = reg_wdata;
        end
        TABLE_INDEX_ADDR: begin
          next_s.table_index = reg_wdata[TABLE_AW-1:0];
        end
        TABLE_DATA_ADDR: begin
          // auto-step so a palette loads as a burst of data writes
          next_s.table_index = s.table_index + TABLE_STEP;
        end
        default: begin
        end
      endcase
      // windows are tested outside the case, which knows fixed indices only
      if (shared_hit) begin
        next_s.shared[shared_idx] = reg_wdata;
      end
      if (panel_hit) begin
        next_s.panel[panel_idx] = reg_wdata;
      end
    end
    if (reg_read) begin
      case (reg_addr)
        BANK_ACCESS_ADDR: begin
          next_s.rdata = s.bank_access;
        end
        CLOCK_SELECT_ADDR: begin
          next_s.rdata = s.clock_select;
        end
        PATH_ASSIGN_ADDR: begin
          next_s.rdata = s.path_assign;
        end
        TABLE_CONTROL_ADDR: begin
          next_s.rdata = s.table_control;
        end
        TABLE_INDEX_ADDR: begin
          next_s.rdata = 8'(s.table_index);
        end
        default: begin
          next_s.rdata = ZERO_BYTE;
        end
      endcase
      // window hits override whatever the fixed-index case chose
      if (paired_hit) begin
        next_s.rdata = paired_rdata;
      end
      if (shared_hit) begin
        next_s.rdata = s.shared[shared_idx];
      end
      if (panel_hit) begin
        next_s.rdata = s.panel[panel_idx];
      end
    end
    // reset sits last so it beats any strobe sampled in the same cycle
    if (rst) begin
      next_s               = '0;
      next_s.bank_access   = BANK_ACCESS_RESET;
      next_s.clock_select  = CLOCK_SELECT_RESET;
      next_s.path_assign   = PATH_ASSIGN_RESET;
      next_s.table_control = TABLE_CONTROL_RESET;
    end
  end

  // one register stage for all control state; rst is folded into next_s
  always_ff @(posedge ref_clk) begin
    s <= next_s;
  end

  // read data come from a flop, one cycle after the strobe and only then
  assign reg_rdata = s.rdata;

  // one color table per controller; a cpu write reaches every enabled one
  assign pixel_index[0] = ctrl1_pixel_index;
  assign pixel_index[1] = ctrl2_pixel_index;

  generate
    for (genvar k = 0; k < 2; k++) begin : g_table
      // both tables take the same index and data; only the enable differs
      assign table_write[k] = strobe_at(reg_write, reg_addr, TABLE_DATA_ADDR)
                              && s.table_control[k];
      color_table #(
        .DEPTH    (TABLE_DEPTH),
        .AW       (TABLE_AW)
      ) u_table (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .write    (table_write[k]),
        .wr_index (s.table_index),
        .wdata    (reg_wdata),
        .rd_index (pixel_index[k]),
        .rd_data  (pixel_color[k])
      );
    end
  endgenerate

  // table outputs are already registered inside each table
  assign ctrl1_color = pixel_color[0];
  assign ctrl2_color = pixel_color[1];

  // output path steering
  assign panel_source = s.path_assign[PATH_PANEL_BIT];
  assign crt_source   = s.path_assign[PATH_CRT_BIT];
  assign cursor_owner = s.path_assign[PATH_CURSOR_BIT];
  assign icon_owner   = s.path_assign[PATH_ICON_BIT];

  // the single cursor and icon appear wherever their owner is routed;
  // the owner bits move only the cursor and icon, not the pixel data
  assign cursor_on_panel = shown_on(cursor_owner, panel_source);
  assign cursor_on_crt   = shown_on(cursor_owner, crt_source);
  assign icon_on_panel   = shown_on(icon_owner, panel_source);
  assign icon_on_crt     = shown_on(icon_owner, crt_source);

  // overlay hangs off controller 1 only, so at most it follows that path;
  // with split routing the overlay appears on one screen at most
  assign overlay_on_panel = fed_by_ctrl1(panel_source);
  assign overlay_on_crt   = fed_by_ctrl1(crt_source);

  // controller 2 lacks vga and panel expansion or centering;
  // a user wanting expansion must route the panel to controller 1
  assign panel_expand_allowed = fed_by_ctrl1(panel_source);
  assign panel_vga_capable    = fed_by_ctrl1(panel_source);
  assign crt_vga_capable      = fed_by_ctrl1(crt_source);

  // per-controller pixel clock rate codes; the codes only name a rate,
  // the dividers that make it sit outside this block
  assign ctrl1_clock_rate = s.clock_select[CLK1_MSB:CLK1_LSB];
  assign ctrl2_clock_rate = s.clock_select[CLK2_MSB:CLK2_LSB];

  // each controller sees only its own copy; the shared copy feeds both
  assign ctrl1_timing  = first_copy;
  assign ctrl2_timing  = second_copy;
  assign shared_timing = s.shared;

  // panel timing goes only to the controller that owns the panel;
  // the other sees zero so it cannot pick up stale panel values
  assign ctrl1_panel_timing = (panel_source == CTRL1) ? s.panel : '0;
  assign ctrl2_panel_timing = (panel_source == CTRL2) ? s.panel : '0;

endmodule // dual_display_routing

//--- test/dual_display_routing_assertions.sv
`timescale 1ns/1ps
module dual_display_routing_assertions
  import duo_pkg::*;
(
  input wire logic                      ref_clk,
  input wire logic                      rst,
  input wire logic [ADDR_W-1:0]         reg_addr,
  input wire logic [DATA_W-1:0]         reg_wdata,
  input wire logic                      reg_write,
  input wire logic                      reg_read,
  input wire logic [DATA_W-1:0]         reg_rdata,
  input wire logic                      panel_source,
  input wire logic                      crt_source,
  input wire logic                      cursor_owner,
  input wire logic                      icon_owner,
  input wire logic                      cursor_on_panel,
  input wire logic                      icon_on_crt,
  input wire logic                      overlay_on_panel,
  input wire logic                      overlay_on_crt,
  input wire logic                      panel_expand_allowed,
  input wire logic                      panel_vga_capable,
  input wire logic                      crt_vga_capable,
  input wire logic [3:0]                ctrl1_clock_rate,
  input wire logic [3:0]                ctrl2_clock_rate
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  // write data of the previous cycle, so checks need no bit-select in $past
  logic [7:0] last_wdata;
  always_ff @(posedge ref_clk) begin
    last_wdata <= reg_wdata;
  end

  // the register steps that routing and the read pulse depend on
  sequence path_wr;
    reg_write && reg_addr == PATH_ASSIGN_ADDR;
  endsequence
  sequence clk_wr;
    reg_write && reg_addr == CLOCK_SELECT_ADDR;
  endsequence
  sequence rd_then_idle;
    reg_read ##1 !reg_read;
  endsequence

  AST_PANEL_SRC: assert property (path_wr |=> panel_source == last_wdata[1])
    else $error("panel source does not follow path write");
  AST_CRT_SRC: assert property (path_wr |=> crt_source == last_wdata[2])
    else $error("crt source does not follow path write");
  AST_PATH_HOLD: assert property (!reg_write |=>
    $stable(panel_source) && $stable(crt_source))
    else $error("path routing moved without a write");
  AST_CAPS: assert property (panel_vga_capable == !panel_source &&
    panel_expand_allowed == !panel_source && crt_vga_capable == !crt_source)
    else $error("controller 2 path offers vga or expansion");
  AST_OVERLAY: assert property (overlay_on_panel == !panel_source &&
    overlay_on_crt == !crt_source)
    else $error("overlay shown on a controller 2 path");
  AST_CLOCK: assert property (clk_wr |=>
    {ctrl2_clock_rate, ctrl1_clock_rate} == last_wdata)
    else $error("clock rates do not follow clock select");
  AST_OWNERS: assert property (path_wr |=> cursor_owner == last_wdata[7] &&
    icon_owner == last_wdata[6])
    else $error("cursor or icon owner wrong");
  AST_SHARED_USE: assert property (cursor_on_panel ==
    (cursor_owner == panel_source) && icon_on_crt == (icon_owner == crt_source))
    else $error("cursor or icon shown on wrong path");
  AST_RESET_OWN: assert property ($fell(rst) |-> !cursor_owner && !icon_owner)
    else $error("cursor or icon not on controller 1 after reset");
  AST_READ_PULSE: assert property (rd_then_idle |=> reg_rdata == ZERO_BYTE)
    else $error("read data stands longer than one cycle");
endmodule // dual_display_routing_assertions

bind dual_display_routing dual_display_routing_assertions
  dual_display_routing_assertions_i (.ref_clk, .rst, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .panel_source, .crt_source,
  .cursor_owner, .icon_owner, .cursor_on_panel, .icon_on_crt,
  .overlay_on_panel, .overlay_on_crt, .panel_expand_allowed,
  .panel_vga_capable, .crt_vga_capable, .ctrl1_clock_rate, .ctrl2_clock_rate);

//--- test/display_outputs_model.sv
`timescale 1ns/1ps
module display_outputs_model (
  input  wire logic       ref_clk,
  input  wire logic       rst,
  input  wire logic [3:0] look_index,
  output logic      [3:0] ctrl1_pixel_index,
  output logic      [3:0] ctrl2_pixel_index
);
  // both screens scan the same pixel, one register stage like a real
  // pixel pipe, so table mirroring shows as equal colors on both paths
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl1_pixel_index <= 4'h0;
      ctrl2_pixel_index <= 4'h0;
    end else begin
      ctrl1_pixel_index <= look_index;
      ctrl2_pixel_index <= look_index;
    end
  end
endmodule // display_outputs_model

//--- test/dual_display_routing_tb.sv
`timescale 1ns/1ps
module dual_display_routing_tb;
  import duo_pkg::*;
  logic ref_clk = 1'b0, rst = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, c1col, c2col;
  logic [3:0] look = 4'h0, p1, p2, r1, r2;
  logic ps, cs, co, io, cp, cc, ip, ic, op, oc, pe, pv, cv;
  logic [63:0] t1, t2, sh;
  logic [127:0] pt1, pt2;
  logic [7:0] m1 [8], m2 [8], d, q;
  int fails = 0, checked = 0, cycles = 0, seed = 32'h7c779d32;

  dual_display_routing dual_display_routing_i (.ref_clk, .rst, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .ctrl1_pixel_index(p1),
    .ctrl2_pixel_index(p2), .ctrl1_color(c1col), .ctrl2_color(c2col),
    .panel_source(ps), .crt_source(cs), .cursor_owner(co), .icon_owner(io),
    .cursor_on_panel(cp), .cursor_on_crt(cc), .icon_on_panel(ip),
    .icon_on_crt(ic), .overlay_on_panel(op), .overlay_on_crt(oc),
    .panel_expand_allowed(pe), .panel_vga_capable(pv), .crt_vga_capable(cv),
    .ctrl1_clock_rate(r1), .ctrl2_clock_rate(r2), .ctrl1_timing(t1),
    .ctrl2_timing(t2), .shared_timing(sh), .ctrl1_panel_timing(pt1),
    .ctrl2_panel_timing(pt2));
  display_outputs_model display_outputs_model_i (.ref_clk, .rst,
    .look_index(look), .ctrl1_pixel_index(p1), .ctrl2_pixel_index(p2));

  // free-running clock, 4 ns period
  always #2 ref_clk = ~ref_clk;

  // hang guard: far above the few hundred cycles the tests need
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      finish_test();
    end
  end

  task automatic finish_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] e,
                       input logic [7:0] g);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, e, g);
    end
  endtask

  // one-cycle strobes, changed just after the edge
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    #1; // callers compare only after the taking edge has settled
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1 v = reg_rdata;
  endtask

  initial begin
    repeat (10) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (m1[k]) begin
      m1[k] = 8'h00;
      m2[k] = 8'h00;
    end
    // reset values of the control registers and routing
    rd(BANK_ACCESS_ADDR, q); check("bank reset", 8'h00, q);
    rd(CLOCK_SELECT_ADDR, q); check("clock reset", 8'h00, q);
    rd(PATH_ASSIGN_ADDR, q); check("path reset", 8'h00, q);
    rd(TABLE_CONTROL_ADDR, q); check("table ctl reset", 8'h03, q);
    check("owners reset", 8'h00, {co, io, ps, cs});
    rd(8'h00, q); check("unmapped read", 8'h00, q);
    $display("test reset done");
    // panel set loaded first, as software does at power-up
    for (int k = 0; k < 16; k++)
      wr(8'(PANEL_FIRST_ADDR + k), 8'(8'h10 + k));
    rd(PANEL_RESERVED, q); check("reserved panel", 8'h00, q);
    // path register: every source combination, random owner bits
    for (int k = 0; k < 8; k++) begin
      d = 8'($random(seed));
      d[2:1] = k[1:0];
      wr(PATH_ASSIGN_ADDR, d);
      check("panel source", d[1], ps);
      check("crt source", d[2], cs);
      check("caps", {3{~d[1]}} & 3'b110 | {2'b0, ~d[2]}, {pe, pv, cv});
      check("overlay", {~d[1], ~d[2]}, {op, oc});
      check("owners", d[7:6], {co, io});
      check("shown", {d[7] == d[1], d[7] == d[2], d[6] == d[1], d[6] == d[2]},
            {cp, cc, ip, ic});
      check("panel set c1", d[1] ? 8'h00 : 8'h13, pt1[31:24]);
      check("panel set c2", d[1] ? 8'h1F : 8'h00, pt2[127:120]);
      d = 8'($random(seed));
      wr(CLOCK_SELECT_ADDR, d);
      check("clock rates", d, {r2, r1});
    end
    $display("test routing done");
    // paired copies: every write-gate setting, both read selects
    for (int k = 0; k < 12; k++) begin
      d = 8'($random(seed));
      wr(BANK_ACCESS_ADDR, {4'h0, k[0], k[1], 2'b00});
      wr(PAIRED_BASE + k[2:0], d);
      if (!k[0]) m1[k[2:0]] = d;
      if (k[1]) m2[k[2:0]] = d;
      check("copy1", m1[k[2:0]], t1[k[2:0]*8 +: 8]);
      check("copy2", m2[k[2:0]], t2[k[2:0]*8 +: 8]);
      wr(BANK_ACCESS_ADDR, 8'h01);
      rd(PAIRED_BASE + k[2:0], q); check("read copy2", m2[k[2:0]], q);
      wr(BANK_ACCESS_ADDR, {6'h0, k[3:2] == 2'b01 ? 2'b11 : k[3:2]});
      rd(PAIRED_BASE + k[2:0], q); check("read copy1", m1[k[2:0]], q);
      // shared register under the copy-2 read select
      wr(SHARED_BASE + k[2:0], ~d);
      wr(BANK_ACCESS_ADDR, 8'h01);
      rd(SHARED_BASE + k[2:0], q); check("shared read", ~d, q);
      check("shared copy", ~d, sh[k[2:0]*8 +: 8]);
    end
    $display("test banks done");
    // color tables: mirrored pair, then second table alone
    wr(TABLE_INDEX_ADDR, 8'h0E);
    wr(TABLE_DATA_ADDR, 8'hA5);
    wr(TABLE_DATA_ADDR, 8'h5A);
    wr(TABLE_CONTROL_ADDR, 8'h02);
    wr(TABLE_DATA_ADDR, 8'hC3);
    for (int k = 0; k < 3; k++) begin
      @(posedge ref_clk);
      look <= 4'hE + k[3:0];
      repeat (3) @(posedge ref_clk);
      #1;
      check("table1", k == 2 ? 8'h00 : (k ? 8'h5A : 8'hA5), c1col);
      check("table2", k == 2 ? 8'hC3 : (k ? 8'h5A : 8'hA5), c2col);
    end
    $display("test tables done");
    finish_test();
  end
endmodule // dual_display_routing_tb
